// file: lane_cfg_slave.v
// Purpose: mode/strap/power control and byte-register bus slave of a 1:2 lane duplicator
// Assumes: SCL and SDA are slow external pins oversampled by REF_CLK
// Notes: SDA is open drain; SDA_OE high pulls the line low
`timescale 1ns/1ps
`include "cfg_defs.vh"
module lane_cfg_slave #(
  parameter [3:0] REVISION = 4'h5 // arbitrary value
) (
  input wire REF_CLK,
  input wire RESETN,
  input wire SCL_IN,
  input wire SDA_IN,
  output reg SDA_OUT,
  output reg SDA_OE,
  output reg SCL_OE,
  input wire MODE_PIN,
  input wire PWRDN_PIN,
  input wire [1:0] BOOST_STRAP_UPPER,
  input wire [1:0] BOOST_STRAP_LOWER,
  input wire [1:0] SWING_GAIN_STRAP,
  input wire [1:0] ADDR_STRAP_HIGH_PAIR,
  input wire [1:0] ADDR_STRAP_MID_PAIR,
  input wire [1:0] ADDR_STRAP_LOW_PAIR,
  output reg TERM_HIZ,
  output reg [3:0] LANE_ENABLE,
  output reg [11:0] BOOST_CODE,
  output reg [7:0] SWING_CODE,
  output reg [7:0] GAIN_CODE
);
  // ****************************************
  // reset and pin synchronisers
  // ****************************************
  reg rst_meta_reg;
  reg rst_n_reg;
  wire [15:0] pins_sync;
  wire scl_s;
  wire sda_s;
  wire mode_s;
  wire pd_s;
  wire [1:0] up_s;
  wire [1:0] lo_s;
  wire [1:0] sf_s;
  wire [5:0] addr_s;

  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // idle bus high, mode and power-down pins have pull-ups
  sync2 #(.W(16), .INIT(16'hF000)) u_sync (
    .clk(REF_CLK),
    .rst_n(rst_n_reg),
    .d({SCL_IN, SDA_IN, MODE_PIN, PWRDN_PIN, BOOST_STRAP_UPPER, BOOST_STRAP_LOWER,
        SWING_GAIN_STRAP, ADDR_STRAP_HIGH_PAIR, ADDR_STRAP_MID_PAIR,
        ADDR_STRAP_LOW_PAIR}),
    .q(pins_sync)
  );
  assign scl_s = pins_sync[15];
  assign sda_s = pins_sync[14];
  assign mode_s = pins_sync[13];
  assign pd_s = pins_sync[12];
  assign up_s = pins_sync[11:10];
  assign lo_s = pins_sync[9:8];
  assign sf_s = pins_sync[7:6];
  assign addr_s = pins_sync[5:0];

  // ****************************************
  // bus edge and condition detection
  // ****************************************
  reg scl_d_reg;
  reg sda_d_reg;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  wire [6:0] my_addr;

  always @(posedge REF_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  // strap levels 0,R,F,1 map straight to pairs 00..11
  assign my_addr = {`ADDR_MSB, addr_s};

  // ****************************************
  // byte-level slave state machine
  // ****************************************
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ACK = 3'h2;
  localparam ST_WRITE = 3'h3;
  localparam ST_READ = 3'h4;
  localparam ST_RACK = 3'h5;

  reg [2:0] state_reg;
  reg [2:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg rw_reg;
  reg index_phase_reg;
  reg [2:0] index_reg;
  reg ack_drive_reg;
  reg [7:0] power_reg;
  reg [7:0] lane_reg [0:3];
  reg [7:0] rd_byte;
  reg got8_reg;
  wire [2:0] lane_sel;
  integer i;
  integer j;

  assign lane_sel = index_reg - `IDX_LANE0;

  // read data mux for the current index
  always @* begin
    case (index_reg)
      `IDX_REVISION: rd_byte = {`REV_UPPER, REVISION};
      `IDX_RESERVED: rd_byte = 8'h00;
      `IDX_POWER: rd_byte = power_reg;
      3'h3: rd_byte = lane_reg[0];
      3'h4: rd_byte = lane_reg[1];
      3'h5: rd_byte = lane_reg[2];
      3'h6: rd_byte = lane_reg[3];
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge REF_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      rw_reg <= 1'b0;
      index_phase_reg <= 1'b0;
      index_reg <= 3'h0;
      ack_drive_reg <= 1'b0;
      got8_reg <= 1'b0;
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
      power_reg <= `POWER_RESET;
      for (i = 0; i < 4; i = i + 1) begin
        lane_reg[i] <= `LANE_RESET;
      end
    end else begin
      SDA_OUT <= 1'b0;
      if (start_cond && !mode_s) begin
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 3'h0;
        got8_reg <= 1'b0;
        SDA_OE <= 1'b0;
      end else if (stop_cond || mode_s) begin
        state_reg <= ST_IDLE;
        SDA_OE <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            SDA_OE <= 1'b0;
          end
          ST_ADDR, ST_WRITE: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              got8_reg <= (bit_cnt_reg == 3'h7);
            end
            // the fall that ends a start also sees a zero count, hence the flag
            if (scl_fall && got8_reg) begin
              got8_reg <= 1'b0;
              if (state_reg == ST_ADDR) begin
                if (shift_reg[7:1] == my_addr) begin
                  rw_reg <= shift_reg[0];
                  index_phase_reg <= ~shift_reg[0];
                  state_reg <= ST_ACK;
                  SDA_OE <= 1'b1;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else begin
                if (index_phase_reg) begin
                  index_reg <= shift_reg[2:0];
                  index_phase_reg <= 1'b0;
                end else begin
                  // read-only bytes take the write silently
                  if (index_reg == `IDX_POWER) begin
                    power_reg <= shift_reg;
                  end else if (index_reg >= `IDX_LANE0 && index_reg <= `IDX_LAST) begin
                    lane_reg[lane_sel[1:0]] <= shift_reg;
                  end
                  index_reg <= index_reg + 3'h1;
                end
                state_reg <= ST_ACK;
                SDA_OE <= 1'b1;
              end
            end
          end
          ST_ACK: begin
            // low held from fall before the ack pulse to the fall after it
            if (scl_fall) begin
              bit_cnt_reg <= 3'h0;
              if (rw_reg) begin
                shift_reg <= {rd_byte[6:0], 1'b0};
                SDA_OE <= ~rd_byte[7];
                state_reg <= ST_READ;
              end else begin
                SDA_OE <= 1'b0;
                state_reg <= ST_WRITE;
              end
            end
          end
          ST_READ: begin
            if (scl_fall) begin
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (bit_cnt_reg == 3'h7) begin
                SDA_OE <= 1'b0;
                index_reg <= index_reg + 3'h1;
                state_reg <= ST_RACK;
              end else begin
                SDA_OE <= ~shift_reg[7];
                shift_reg <= {shift_reg[6:0], 1'b0};
              end
            end
          end
          ST_RACK: begin
            // master ack keeps reading, nack ends the transfer
            if (scl_rise) begin
              if (sda_s) begin
                state_reg <= ST_IDLE;
              end else begin
                state_reg <= ST_ACK;
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
            SDA_OE <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // output selection: straps or registers
  // ****************************************
  reg [2:0] pin_boost;
  reg [1:0] pin_swing;
  reg [1:0] pin_gain;
  reg [11:0] boost_next;
  reg [7:0] swing_next;
  reg [7:0] gain_next;
  reg [3:0] enable_next;

  always @* begin
    pin_boost = {up_s, (lo_s == `LVL_F)};
    pin_swing = (sf_s == `LVL_F || sf_s == `LVL_1) ? `SWING_1200 : `SWING_1000;
    pin_gain = (sf_s == `LVL_R || sf_s == `LVL_1) ? `GAIN_M05 : `GAIN_M35;
    // swing and gain codes are passed as register encodings
    boost_next = 12'h000;
    swing_next = 8'h00;
    gain_next = 8'h00;
    for (j = 0; j < 4; j = j + 1) begin
      if (mode_s) begin
        boost_next[j*3 +: 3] = pin_boost;
        swing_next[j*2 +: 2] = pin_swing;
        gain_next[j*2 +: 2] = pin_gain;
      end else begin
        boost_next[j*3 +: 3] = lane_reg[j][`BOOST_LSB +: 3];
        swing_next[j*2 +: 2] = lane_reg[j][`SWING_LSB +: 2];
        gain_next[j*2 +: 2] = lane_reg[j][`GAIN_LSB +: 2];
      end
    end
    enable_next = pd_s ? 4'h0 : (mode_s ? 4'hF : ~power_reg[7:4]);
  end

  always @(posedge REF_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      TERM_HIZ <= 1'b1;
      LANE_ENABLE <= 4'h0;
      BOOST_CODE <= 12'h000;
      SWING_CODE <= 8'h55;
      GAIN_CODE <= 8'hAA;
      SCL_OE <= 1'b0;
    end else begin
      TERM_HIZ <= pd_s;
      LANE_ENABLE <= enable_next;
      BOOST_CODE <= boost_next;
      SWING_CODE <= swing_next;
      GAIN_CODE <= gain_next;
      SCL_OE <= 1'b0;
    end
  end
endmodule

// file: cfg_defs.vh
// Purpose: constants for the lane configuration slave
// Assumes: 20 MHz REF_CLK; bus and strap pins sampled by it
// Notes: four-level straps arrive pre-digitised as 2-bit level codes 0,R,F,1 = 0..3
`ifndef CFG_DEFS_VH
`define CFG_DEFS_VH
`define IDX_REVISION 3'h0
`define IDX_RESERVED 3'h1
`define IDX_POWER 3'h2
`define IDX_LANE0 3'h3
`define IDX_LAST 3'h6
`define REV_UPPER 4'h3
`define POWER_RESET 8'h0D
`define LANE_RESET 8'h09
`define ADDR_MSB 1'b1
`define BOOST_LSB 3'h4
`define GAIN_LSB 3'h2
`define SWING_LSB 3'h0
`define LVL_R 2'h1
`define LVL_F 2'h2
`define LVL_1 2'h3
`define SWING_800 2'h0
`define SWING_1000 2'h1
`define SWING_1100 2'h2
`define SWING_1200 2'h3
`define GAIN_M35 2'h0
`define GAIN_M05 2'h2
`endif

// file: sync2.v
// Purpose: two-flop synchroniser for a bundle of slow pins
// Assumes: active-low asynchronous reset, reset value per bit
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module sync2 #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= INIT;
      q <= INIT;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// file: lane_cfg_chk.sv
// Purpose: port checker for the lane configuration slave
// Assumes: straps held steady in a scenario; outputs settle within 8 cycles
// Notes: pin paths lag by a few cycles, so antecedents ask for 8 steady cycles
`timescale 1ns/1ps
module lane_cfg_chk (
  input wire REF_CLK,
  input wire RESETN,
  input wire SCL_IN,
  input wire SDA_OUT,
  input wire SDA_OE,
  input wire SCL_OE,
  input wire MODE_PIN,
  input wire PWRDN_PIN,
  input wire [1:0] BOOST_STRAP_UPPER,
  input wire [1:0] BOOST_STRAP_LOWER,
  input wire [1:0] SWING_GAIN_STRAP,
  input wire TERM_HIZ,
  input wire [3:0] LANE_ENABLE,
  input wire [11:0] BOOST_CODE,
  input wire [7:0] SWING_CODE,
  input wire [7:0] GAIN_CODE
);
  // ****
  // properties
  // ****
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  sequence strap_still;
    (MODE_PIN && !PWRDN_PIN && $stable({BOOST_STRAP_UPPER, BOOST_STRAP_LOWER,
      SWING_GAIN_STRAP}))[*8];
  endsequence
  clk_free_a: assert property (!SCL_OE)
    else $error("slave drove the clock line");
  oe_pulls_low_a: assert property (SDA_OE |-> !SDA_OUT)
    else $error("data driven high");
  bit_hold_a: assert property ($rose(SCL_IN) |=> $stable(SDA_OE)[*3])
    else $error("data changed while clock high");
  pd_hiz_a: assert property (PWRDN_PIN[*8] |-> TERM_HIZ && LANE_ENABLE == 4'h0)
    else $error("power-down not applied");
  run_on_a: assert property (!PWRDN_PIN[*8] |-> !TERM_HIZ)
    else $error("terminations idle while running");
  pin_quiet_a: assert property (MODE_PIN[*8] |-> !SDA_OE)
    else $error("bus answered in pin mode");
  strap_boost_a: assert property (strap_still |->
    BOOST_CODE == {4{BOOST_STRAP_UPPER, BOOST_STRAP_LOWER == 2'h2}})
    else $error("boost differs from straps");
  strap_level_a: assert property (strap_still |-> LANE_ENABLE == 4'hF &&
    SWING_CODE == {4{SWING_GAIN_STRAP[1], 1'b1}} && GAIN_CODE == {4{SWING_GAIN_STRAP[0], 1'b0}})
    else $error("swing or gain differs from strap");
  rst_dflt_a: assert property ($rose(RESETN) |->
    SWING_CODE == 8'h55 && GAIN_CODE == 8'hAA)
    else $error("lane defaults wrong at reset");
  cover property (SDA_OE && $rose(SCL_IN));
  cover property (strap_still);
  cover property (PWRDN_PIN[*8]);
endmodule
bind lane_cfg_slave lane_cfg_chk chk_u (.REF_CLK(REF_CLK), .RESETN(RESETN), .SCL_IN(SCL_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SCL_OE(SCL_OE), .MODE_PIN(MODE_PIN),
  .PWRDN_PIN(PWRDN_PIN), .BOOST_STRAP_UPPER(BOOST_STRAP_UPPER),
  .BOOST_STRAP_LOWER(BOOST_STRAP_LOWER), .SWING_GAIN_STRAP(SWING_GAIN_STRAP),
  .TERM_HIZ(TERM_HIZ), .LANE_ENABLE(LANE_ENABLE), .BOOST_CODE(BOOST_CODE),
  .SWING_CODE(SWING_CODE), .GAIN_CODE(GAIN_CODE));

// file: bus_master_model.sv
// Purpose: bus master model that bit-bangs clock and data
// Assumes: 8 REF_CLK cycles per bus bit; data line pulled up
// Notes: clock idles high between frames; released data reads high
`timescale 1ns/1ps
module bus_master_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ****
  // framing and bits
  // ****
  task automatic start();
    sda_low <= 1'b0;
    q(4);
    scl <= 1'b1;
    q(2);
    sda_low <= 1'b1;
    q(2);
    scl <= 1'b0;
    q(2);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    q(2);
    scl <= 1'b1;
    q(2);
    sda_low <= 1'b0;
    q(4);
  endtask
  // data changes only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    sda_low <= ~b;
    q(2);
    scl <= 1'b1;
    q(2);
    s = sda;
    q(2);
    scl <= 1'b0;
    q(2);
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin // msb first
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // last byte of a read gets no acknowledge
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, s);
  endtask
endmodule

// file: lane_cfg_slave_bench.sv
// Purpose: self-checking bench for the lane configuration slave
// Assumes: address straps R,F,1 give bus address 5Bh
// Notes: bus timing is fixed by the master model, so waits are fixed counts
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module lane_cfg_slave_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mode = 1'b1;
  logic pwrdn = 1'b0;
  logic [1:0] up = 2'h0, lo = 2'h0, sf = 2'h0;
  logic scl, sda_low, sda_oe, sda_out, scl_oe, term_hiz, a;
  logic [3:0] lane_en;
  logic [11:0] boost;
  logic [7:0] swing, gain;
  logic [7:0] wd[8], ex[8];
  int err_count = 0, checked = 0;
  wire sda_w = ~(sda_low | sda_oe);
  wire scl_w = scl & ~scl_oe;
  // strap rows: upper, lower, swing/gain strap, then boost, swing, gain codes
  logic [12:0] rows[8] = '{{2'h0, 2'h0, 2'h0, 3'h0, 2'h1, 2'h0}, {2'h0, 2'h2, 2'h1, 3'h1, 2'h1, 2'h2},
    {2'h1, 2'h0, 2'h2, 3'h2, 2'h3, 2'h0}, {2'h1, 2'h2, 2'h3, 3'h3, 2'h3, 2'h2},
    {2'h2, 2'h0, 2'h0, 3'h4, 2'h1, 2'h0}, {2'h2, 2'h2, 2'h1, 3'h5, 2'h1, 2'h2},
    {2'h3, 2'h0, 2'h2, 3'h6, 2'h3, 2'h0}, {2'h3, 2'h2, 2'h3, 3'h7, 2'h3, 2'h2}};
  bus_master_model m_u (.clk(clk), .sda(sda_w), .scl(scl), .sda_low(sda_low));
  lane_cfg_slave dut_u (.REF_CLK(clk), .RESETN(rst_n), .SCL_IN(scl_w), .SDA_IN(sda_w),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SCL_OE(scl_oe), .MODE_PIN(mode), .PWRDN_PIN(pwrdn),
    .BOOST_STRAP_UPPER(up), .BOOST_STRAP_LOWER(lo), .SWING_GAIN_STRAP(sf),
    .ADDR_STRAP_HIGH_PAIR(2'h1), .ADDR_STRAP_MID_PAIR(2'h2), .ADDR_STRAP_LOW_PAIR(2'h3),
    .TERM_HIZ(term_hiz), .LANE_ENABLE(lane_en), .BOOST_CODE(boost), .SWING_CODE(swing),
    .GAIN_CODE(gain));
  task automatic test_done();
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ****
  // bus helpers
  // ****
  task automatic rd_all();
    logic ack;
    logic [7:0] v;
    m_u.start();
    m_u.wr_byte(8'hB6, ack);
    m_u.wr_byte(8'h00, ack);
    m_u.start();
    m_u.wr_byte(8'hB7, ack);
    `CHK(ack, 1'b1)
    for (int i = 0; i < 8; i++) begin
      m_u.rd_byte(i == 7, v);
      `CHK(v, ex[i])
    end
    m_u.stop();
  endtask
  initial begin
    forever #25 clk = ~clk;
  end
  // ****
  // sequence
  // ****
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    foreach (rows[i]) begin
      {up, lo, sf} <= rows[i][12:7];
      repeat (8) @(posedge clk);
      `CHK(boost, {4{rows[i][6:4]}})
      `CHK({swing, gain}, {{4{rows[i][3:2]}}, {4{rows[i][1:0]}}})
    end
    m_u.start();
    m_u.wr_byte(8'hB6, a);
    m_u.stop();
    `CHK(a, 1'b0)
    mode <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK({lane_en, boost, swing, gain}, {4'hF, 12'h000, 8'h55, 8'hAA})
    ex = '{8'h35, 8'h00, 8'h0D, 8'h09, 8'h09, 8'h09, 8'h09, 8'h00};
    rd_all();
    m_u.start();
    m_u.wr_byte(8'hB4, a);
    m_u.stop();
    `CHK(a, 1'b0)
    wd = '{8'hA3, 8'h7E, 8'h1B, 8'h2C, 8'h4D, 8'hFF, 8'hFF, 8'hFF};
    m_u.start();
    m_u.wr_byte(8'hB6, a);
    m_u.wr_byte(8'h02, a);
    `CHK(a, 1'b1)
    foreach (wd[i]) begin
      m_u.wr_byte(wd[i], a);
      `CHK(a, 1'b1)
    end
    m_u.stop();
    repeat (8) @(posedge clk);
    `CHK(lane_en, 4'h5)
    `CHK(boost, 12'h88F)
    `CHK(swing, 8'h4E)
    `CHK(gain, 8'hFB)
    ex = '{8'h35, 8'h00, 8'hA3, 8'h7E, 8'h1B, 8'h2C, 8'h4D, 8'h00};
    rd_all();
    pwrdn <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK({term_hiz, lane_en}, 5'h10)
    pwrdn <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK(term_hiz, 1'b0)
    test_done();
  end
endmodule
